// ### verilog/hub_conn_policy_regs.vh
// Purpose: Constants for the hub port connection policy block
// Assumes: 25 MHz core clock, word-aligned register offsets
// Notes: Capability vectors are {usb4, vendor_tunnel, dp, usb32, usb20}
`ifndef HUB_CONN_POLICY_REGS_VH
`define HUB_CONN_POLICY_REGS_VH

// Register byte offsets
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_PORTS 4'h8
`define REG_MODES 4'hc

// Control field positions and reset value
`define CTRL_PR_PREF_BIT 0
`define CTRL_SRC_PREF_BIT 1
`define CTRL_RESCAN_BIT 2
`define CTRL_RESET 3'h0

// Capability bit positions
`define CAP_USB4 4
`define CAP_VTUN 3
`define CAP_DP 2
`define CAP_USB32 1
`define CAP_USB20 0
`define CAP_FALLBACK 5'h03
`define CAP_NONE 5'h00

// Connection modes
`define MODE_NONE 3'h0
`define MODE_USB4 3'h1
`define MODE_VTUN 3'h2
`define MODE_DP 3'h3
`define MODE_USB32 3'h4
`define MODE_USB20 3'h5

// Enter_USB operation field and upstream link protocol codes
`define OP_USB20 2'h0
`define OP_USB32 2'h1
`define OP_USB4 2'h2

// Timing
`define CLK_KHZ 25000
`define USB4_WAIT_MS 1000
`define USB4_WAIT_CYC (`USB4_WAIT_MS * `CLK_KHZ)
`define ALT_WAIT_MS 1000
`define ALT_WAIT_CYC (`ALT_WAIT_MS * `CLK_KHZ)
`define PORT_RST_CYC 16'h0010

`endif

// ### verilog/hub_conn_policy.v
// Purpose: Upstream capability tracking and downstream port connection policy of a USB4 hub
// Assumes: PD message layer and port managers run on core_clk_in; their strobes are one-cycle pulses
// Notes: Registers on a plain strobe port, read data valid the cycle after the read strobe
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "hub_conn_policy_regs.vh"

module hub_conn_policy #(
    parameter NPORTS = 4,
    parameter [4:0] HUB_CAPS = 5'h1f,
    parameter [31:0] USB4_WAIT_CYC = `USB4_WAIT_CYC,
    parameter [31:0] ALT_WAIT_CYC = `ALT_WAIT_CYC,
    parameter [15:0] PORT_RST_CYC = `PORT_RST_CYC
) (
    // Clock and reset
    input wire core_clk_in,
    input wire rst_n_in,
    // Register port
    input wire [3:0] reg_addr_in,
    input wire [31:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    output reg [31:0] reg_rdata_out,
    // Upstream port role handling
    input wire ufp_contract_done_in,
    input wire ufp_is_source_in,
    input wire ufp_is_host_role_in,
    output reg pr_swap_req_out,
    output reg dr_swap_req_out,
    // Upstream PD events
    input wire ufp_attach_in,
    input wire data_reset_in,
    input wire enter_usb_rx_in,
    input wire [1:0] enter_usb_op_in,
    input wire [3:1] enter_usb_feat_in,
    input wire enter_usb_host_present_in,
    input wire ufp_partner_is_hub_in,
    input wire enter_mode_rx_in,
    input wire enter_mode_vtun_in,
    input wire enter_mode_dp_in,
    // Upstream link state
    input wire ufp_link_up_in,
    input wire [1:0] ufp_link_proto_in,
    // Upstream status
    output reg host_known_out,
    output reg [4:0] host_cap_out,
    output reg usb32_hub_mode_out,
    output reg billboard_out,
    // Downstream port managers
    input wire [NPORTS-1:0] dfp_attach_in,
    input wire [NPORTS-1:0] dfp_detach_in,
    input wire [NPORTS-1:0] dfp_disc_done_in,
    input wire [4*NPORTS-1:0] dfp_dev_caps_in,
    input wire [NPORTS-1:0] dfp_dev_is_hub_in,
    output wire [NPORTS-1:0] dfp_disc_req_out,
    output wire [3*NPORTS-1:0] dfp_mode_out,
    output wire [NPORTS-1:0] dfp_notify_en_out,
    output wire [NPORTS-1:0] dfp_path_en_out,
    output wire [NPORTS-1:0] dfp_port_reset_out,
    output wire [NPORTS-1:0] dfp_ess_tunnel_out,
    output wire [NPORTS-1:0] dfp_dp_tunnel_out,
    output wire [NPORTS-1:0] dfp_eusb_send_out,
    output wire [NPORTS-1:0] dfp_eusb_hp_out
);

    // Upstream states
    localparam [2:0] U_IDLE = 3'h1;
    localparam [2:0] U_WAIT = 3'h2;
    localparam [2:0] U_DONE = 3'h4;
    // Downstream port states
    localparam [5:0] P_EMPTY = 6'h01;
    localparam [5:0] P_DISC = 6'h02;
    localparam [5:0] P_SPEC = 6'h04;
    localparam [5:0] P_EVAL = 6'h08;
    localparam [5:0] P_ACT = 6'h10;
    localparam [5:0] P_RST = 6'h20;

    reg [2:0] ctrl_reg;
    reg [2:0] ustate_reg;
    reg [31:0] usb4_tmr_reg;
    reg [31:0] alt_tmr_reg;
    reg [4:0] msg_cap_reg;
    reg known_d_reg;
    reg [4:0] cap_d_reg;
    reg recheck_reg;
    wire [4:0] proto_mask;
    wire [4:0] host_cap_next;
    wire host_known_next;
    wire [4:0] port_limit;
    wire [NPORTS-1:0] port_act;

    // Highest mode both sides allow, fixed priority order
    function [2:0] pick_mode;
        input [4:0] caps;
        begin
            pick_mode = caps[`CAP_USB4] ? `MODE_USB4 : caps[`CAP_VTUN] ? `MODE_VTUN :
                        caps[`CAP_DP] ? `MODE_DP : caps[`CAP_USB32] ? `MODE_USB32 : `MODE_USB20;
        end
    endfunction

    // Whether a mode is carried by the given upstream capability set
    function mode_ok;
        input [2:0] mode;
        input [4:0] cap;
        begin
            case (mode)
                `MODE_USB4: mode_ok = cap[`CAP_USB4];
                `MODE_VTUN: mode_ok = cap[`CAP_USB4] | cap[`CAP_VTUN];
                `MODE_DP: mode_ok = cap[`CAP_USB4] | cap[`CAP_DP];
                `MODE_USB32: mode_ok = cap[`CAP_USB4] | cap[`CAP_USB32];
                default: mode_ok = 1'b1;
            endcase
        end
    endfunction

    // Protocol actually reached on the upstream link caps what the message claims
    assign proto_mask = (ufp_link_proto_in == `OP_USB4) ? 5'h1f :
                        (ufp_link_proto_in == `OP_USB32) ? `CAP_FALLBACK : 5'h01;
    assign host_known_next = ustate_reg[2] & ufp_link_up_in;
    assign host_cap_next = host_known_next ? (msg_cap_reg & proto_mask) : `CAP_NONE;
    // Before the host is known, ports connect on the hub's own capabilities
    assign port_limit = host_known_out ? (host_cap_out & HUB_CAPS) : HUB_CAPS;

    // Upstream capability discovery
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ustate_reg <= U_IDLE;
            usb4_tmr_reg <= 32'h0000_0000;
            alt_tmr_reg <= 32'h0000_0000;
            msg_cap_reg <= `CAP_NONE;
            billboard_out <= 1'b0;
        end else if (ufp_attach_in || data_reset_in) begin
            ustate_reg <= U_WAIT;
            usb4_tmr_reg <= 32'h0000_0000;
            alt_tmr_reg <= 32'h0000_0000;
            msg_cap_reg <= `CAP_NONE;
            billboard_out <= 1'b0;
        end else begin
            case (ustate_reg)
                U_IDLE: ustate_reg <= U_IDLE;
                U_WAIT: begin
                    usb4_tmr_reg <= usb4_tmr_reg + 32'h0000_0001;
                    alt_tmr_reg <= alt_tmr_reg + 32'h0000_0001;
                    if (enter_usb_rx_in && (enter_usb_host_present_in || !ufp_partner_is_hub_in)) begin
                        // Without the flag an upstream hub speaks only for itself
                        ustate_reg <= U_DONE;
                        case (enter_usb_op_in)
                            `OP_USB4: msg_cap_reg <= {1'b1, enter_usb_feat_in, 1'b1};
                            `OP_USB32: msg_cap_reg <= `CAP_FALLBACK;
                            default: msg_cap_reg <= 5'h01;
                        endcase
                    end else if (enter_mode_rx_in && (enter_mode_vtun_in || enter_mode_dp_in)) begin
                        ustate_reg <= U_DONE;
                        msg_cap_reg <= {1'b0, enter_mode_vtun_in, enter_mode_dp_in, 2'b11};
                    end else if (usb4_tmr_reg >= USB4_WAIT_CYC - 32'h0000_0001 ||
                                 alt_tmr_reg >= ALT_WAIT_CYC - 32'h0000_0001) begin
                        ustate_reg <= U_DONE;
                        msg_cap_reg <= `CAP_FALLBACK;
                        billboard_out <= (usb4_tmr_reg >= USB4_WAIT_CYC - 32'h0000_0001);
                    end
                end
                U_DONE: begin
                    // A later message may still raise the host-present flag
                    if (enter_usb_rx_in && enter_usb_host_present_in && enter_usb_op_in == `OP_USB4) begin
                        msg_cap_reg <= {1'b1, enter_usb_feat_in, 1'b1};
                    end
                end
                default: ustate_reg <= U_IDLE;
            endcase
        end
    end

    // Published host view, and a one-cycle recheck when the host becomes known or its caps change while known
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            host_known_out <= 1'b0;
            host_cap_out <= `CAP_NONE;
            known_d_reg <= 1'b0;
            cap_d_reg <= `CAP_NONE;
            recheck_reg <= 1'b0;
            usb32_hub_mode_out <= 1'b0;
        end else begin
            host_known_out <= host_known_next;
            host_cap_out <= host_cap_next;
            known_d_reg <= host_known_out;
            cap_d_reg <= host_cap_out;
            recheck_reg <= host_known_out && (!known_d_reg || cap_d_reg != host_cap_out);
            usb32_hub_mode_out <= host_known_next && !host_cap_next[`CAP_USB4];
        end
    end

    // Role swaps after each contract
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pr_swap_req_out <= 1'b0;
            dr_swap_req_out <= 1'b0;
        end else begin
            pr_swap_req_out <= ufp_contract_done_in && ctrl_reg[`CTRL_PR_PREF_BIT] &&
                               (ufp_is_source_in != ctrl_reg[`CTRL_SRC_PREF_BIT]);
            dr_swap_req_out <= ufp_contract_done_in && ufp_is_host_role_in;
        end
    end

    // One policy engine per downstream port
    genvar gi;
    generate
        for (gi = 0; gi < NPORTS; gi = gi + 1) begin : g_port
            reg [5:0] st_reg;
            reg [2:0] mode_reg;
            reg [15:0] rst_cnt_reg;
            reg was_dp_reg;
            reg disc_req_reg;
            reg notify_reg;
            reg path_reg;
            reg ess_reg;
            reg dpt_reg;
            reg send_reg;
            reg hp_reg;
            reg rst_out_reg;
            reg spec_sent_reg;
            wire [4:0] dev_caps;
            assign dev_caps = {dfp_dev_caps_in[4*gi+3 -: 4], 1'b1};
            always @(posedge core_clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    st_reg <= P_EMPTY;
                    mode_reg <= `MODE_NONE;
                    rst_cnt_reg <= 16'h0000;
                    was_dp_reg <= 1'b0;
                    disc_req_reg <= 1'b0;
                    notify_reg <= 1'b0;
                    path_reg <= 1'b0;
                    ess_reg <= 1'b0;
                    dpt_reg <= 1'b0;
                    send_reg <= 1'b0;
                    hp_reg <= 1'b0;
                    rst_out_reg <= 1'b0;
                    spec_sent_reg <= 1'b0;
                end else if (dfp_detach_in[gi]) begin
                    st_reg <= P_EMPTY;
                    mode_reg <= `MODE_NONE;
                    was_dp_reg <= 1'b0;
                    disc_req_reg <= 1'b0;
                    notify_reg <= 1'b0;
                    path_reg <= 1'b0;
                    ess_reg <= 1'b0;
                    dpt_reg <= 1'b0;
                    send_reg <= 1'b0;
                    hp_reg <= 1'b0;
                    rst_out_reg <= 1'b0;
                end else begin
                    disc_req_reg <= 1'b0;
                    send_reg <= 1'b0;
                    case (st_reg)
                        P_EMPTY: begin
                            if (dfp_attach_in[gi]) begin
                                st_reg <= P_DISC;
                                disc_req_reg <= 1'b1;
                            end
                        end
                        P_DISC: begin
                            // A silent device still ends discovery, with no caps reported
                            if (dfp_disc_done_in[gi]) begin
                                if (was_dp_reg && !port_limit[`CAP_USB4] && !port_limit[`CAP_DP]) begin
                                    mode_reg <= `MODE_USB20;
                                end else begin
                                    mode_reg <= pick_mode(dev_caps & port_limit);
                                end
                                st_reg <= host_known_out ? P_EVAL : P_SPEC;
                                was_dp_reg <= 1'b0;
                                spec_sent_reg <= 1'b0;
                            end
                        end
                        P_SPEC: begin
                            notify_reg <= 1'b0;
                            path_reg <= 1'b0;
                            // Downstream hub learns the caps are not yet the host's
                            if (mode_reg == `MODE_USB4 && dfp_dev_is_hub_in[gi] && !spec_sent_reg) begin
                                send_reg <= 1'b1;
                                spec_sent_reg <= 1'b1;
                            end
                            if (host_known_out) begin
                                st_reg <= P_EVAL;
                            end
                        end
                        P_EVAL: begin
                            if (mode_ok(mode_reg, host_cap_out & HUB_CAPS)) begin
                                st_reg <= P_ACT;
                                notify_reg <= 1'b1;
                                path_reg <= 1'b1;
                                ess_reg <= host_cap_out[`CAP_USB4] &&
                                           (mode_reg == `MODE_USB32 || mode_reg == `MODE_DP);
                                dpt_reg <= host_cap_out[`CAP_USB4] && mode_reg == `MODE_DP;
                                if (mode_reg == `MODE_USB4 && dfp_dev_is_hub_in[gi] && !hp_reg) begin
                                    send_reg <= 1'b1;
                                    hp_reg <= 1'b1;
                                end
                            end else begin
                                st_reg <= P_RST;
                                rst_out_reg <= 1'b1; // Held through teardown, dropped on reconnect
                                was_dp_reg <= (mode_reg == `MODE_DP);
                                rst_cnt_reg <= 16'h0000;
                                notify_reg <= 1'b0;
                                path_reg <= 1'b0;
                                ess_reg <= 1'b0;
                                dpt_reg <= 1'b0;
                                hp_reg <= 1'b0;
                            end
                        end
                        P_ACT: begin
                            st_reg <= (recheck_reg || ctrl_reg[`CTRL_RESCAN_BIT]) ? P_EVAL : P_ACT;
                        end
                        P_RST: begin
                            rst_cnt_reg <= rst_cnt_reg + 16'h0001;
                            if (rst_cnt_reg >= PORT_RST_CYC - 16'h0001) begin
                                st_reg <= P_DISC;
                                mode_reg <= `MODE_NONE;
                                disc_req_reg <= 1'b1;
                                rst_out_reg <= 1'b0;
                            end
                        end
                        default: st_reg <= P_EMPTY;
                    endcase
                end
            end
            assign port_act[gi] = (st_reg == P_ACT);
            assign dfp_disc_req_out[gi] = disc_req_reg;
            assign dfp_mode_out[3*gi+2 -: 3] = mode_reg;
            assign dfp_notify_en_out[gi] = notify_reg;
            assign dfp_path_en_out[gi] = path_reg;
            assign dfp_port_reset_out[gi] = rst_out_reg;
            assign dfp_ess_tunnel_out[gi] = ess_reg;
            assign dfp_dp_tunnel_out[gi] = dpt_reg;
            assign dfp_eusb_send_out[gi] = send_reg;
            assign dfp_eusb_hp_out[gi] = hp_reg;
        end
    endgenerate

    // Register writes; rescan is a self-clearing command bit
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_reg <= `CTRL_RESET;
        end else if (reg_wr_in && reg_addr_in == `REG_CTRL) begin
            ctrl_reg <= reg_wdata_in[2:0];
        end else begin
            ctrl_reg[`CTRL_RESCAN_BIT] <= 1'b0;
        end
    end

    // Register reads, data one cycle after the strobe; unmapped reads return zero
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= 32'h0000_0000;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                `REG_CTRL: reg_rdata_out <= {29'h0000_0000, ctrl_reg};
                `REG_STATUS: reg_rdata_out <= {16'h0000, billboard_out, usb32_hub_mode_out, host_known_out,
                                               ustate_reg, msg_cap_reg, host_cap_out};
                `REG_PORTS: reg_rdata_out <= {{(32-NPORTS){1'b0}}, port_act};
                `REG_MODES: reg_rdata_out <= {{(32-3*NPORTS){1'b0}}, dfp_mode_out};
                default: reg_rdata_out <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata_out <= 32'h0000_0000;
        end
    end

endmodule

// ### verification/hub_conn_policy_checker.sv
// Purpose: Temporal checks on the hub connection policy ports
// Assumes: One core clock, asynchronous active-low reset
// Notes: Port 0 or the port with the matching device stands for all ports
`timescale 1ns/1ps
`include "hub_conn_policy_regs.vh"
module hub_conn_policy_checker #(
    parameter NPORTS = 4
) (
    // Clock, reset and causes
    input wire core_clk_in,
    input wire rst_n_in,
    input wire reg_rd_in,
    input wire ufp_contract_done_in,
    input wire [NPORTS-1:0] dfp_attach_in,
    // Watched outputs
    input wire [31:0] reg_rdata_out,
    input wire dr_swap_req_out,
    input wire host_known_out,
    input wire [4:0] host_cap_out,
    input wire usb32_hub_mode_out,
    input wire billboard_out,
    input wire [NPORTS-1:0] dfp_disc_req_out,
    input wire [3*NPORTS-1:0] dfp_mode_out,
    input wire [NPORTS-1:0] dfp_path_en_out,
    input wire [NPORTS-1:0] dfp_port_reset_out,
    input wire [NPORTS-1:0] dfp_dp_tunnel_out,
    input wire [NPORTS-1:0] dfp_eusb_send_out,
    input wire [NPORTS-1:0] dfp_eusb_hp_out
);
    // All checks share the core clock and sleep while reset is low
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);

    // Read data shows only in the cycle after a read strobe
    rdata_idle_zero_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0000_0000)
        else $error("read data not zero outside a read");
    swap_after_contract_a: assert property (dr_swap_req_out |-> $past(ufp_contract_done_in))
        else $error("data role swap without a contract");
    disc_after_attach_a: assert property (dfp_attach_in[0] |=> dfp_disc_req_out[0])
        else $error("no discovery after attach");
    spec_path_held_a: assert property (|dfp_path_en_out |-> host_known_out)
        else $error("path enabled before host known");
    usb4_mode_allowed_a: assert property (dfp_path_en_out[0] && dfp_mode_out[2:0] == `MODE_USB4
        |-> host_cap_out[`CAP_USB4])
        else $error("USB4 port enabled without USB4 host");
    fallback_no_usb4_a: assert property (usb32_hub_mode_out && dfp_path_en_out[0]
        |-> dfp_mode_out[2:0] != `MODE_USB4)
        else $error("USB4 port live in fallback hub mode");
    dp_tunnel_usb4_a: assert property (dfp_dp_tunnel_out[2]
        |-> host_cap_out[`CAP_USB4] && dfp_mode_out[8:6] == `MODE_DP)
        else $error("display tunnel without USB4 host");
    reset_hold_a: assert property ($rose(dfp_port_reset_out[0])
        |-> (dfp_port_reset_out[0] && !dfp_path_en_out[0])[*8])
        else $error("port reset too short or path open");
    billboard_fallback_a: assert property ($rose(billboard_out)
        |-> ##[0:2] host_cap_out == `CAP_FALLBACK)
        else $error("billboard without fallback caps");
    hp_resend_a: assert property ($rose(dfp_eusb_hp_out[0]) |-> dfp_eusb_send_out[0] && host_known_out)
        else $error("host-present flag raised without a resend");
endmodule

// ### verification/dfp_partner_model.sv
// Purpose: Downstream port managers and attached devices
// Assumes: Discovery request is a one-cycle pulse per port
// Notes: Port i answers after 2+3*i cycles, so answers come fast and slow
`timescale 1ns/1ps
module dfp_partner_model #(
    parameter NPORTS = 4
) (
    // Clock and reset
    input wire core_clk_in,
    input wire rst_n_in,
    // Devices chosen by the bench
    input wire [4*NPORTS-1:0] caps_in,
    input wire [NPORTS-1:0] is_hub_in,
    // Toward the policy block
    input wire [NPORTS-1:0] disc_req_in,
    output reg [NPORTS-1:0] disc_done_out,
    output wire [4*NPORTS-1:0] dev_caps_out,
    output wire [NPORTS-1:0] dev_is_hub_out
);
    integer cnt [0:NPORTS-1];
    integer i;
    // Capabilities are fixed properties of what is plugged in
    assign dev_caps_out = caps_in;
    assign dev_is_hub_out = is_hub_in;
    // Each port answers discovery after its own delay, even a plain device
    always @(posedge core_clk_in or negedge rst_n_in) begin
        for (i = 0; i < NPORTS; i = i + 1) begin
            if (!rst_n_in) begin
                cnt[i] <= 0;
                disc_done_out[i] <= 1'b0;
            end else begin
                disc_done_out[i] <= (cnt[i] == 1);
                if (disc_req_in[i])
                    cnt[i] <= 2 + 3 * i;
                else if (cnt[i] != 0)
                    cnt[i] <= cnt[i] - 1;
            end
        end
    end
endmodule

// ### verification/hub_conn_policy_tb.sv
// Purpose: Self-checking bench for the hub connection policy
// Assumes: Entry waits shortened to 100 cycles, four downstream ports
// Notes: Reads are queued by the driver and compared by a watcher
`timescale 1ns/1ps
`include "hub_conn_policy_regs.vh"
module hub_conn_policy_tb;
    localparam NPORTS = 4;
    logic core_clk_in, rst_n_in, reg_wr_in, reg_rd_in, rd_d, ufp_contract_done_in, ufp_is_source_in;
    logic ufp_is_host_role_in, pr_swap_req_out, dr_swap_req_out, ufp_attach_in, data_reset_in, enter_usb_rx_in;
    logic enter_usb_host_present_in, ufp_partner_is_hub_in, enter_mode_rx_in, enter_mode_vtun_in, enter_mode_dp_in;
    logic ufp_link_up_in, host_known_out, usb32_hub_mode_out, billboard_out;
    logic [3:0] reg_addr_in, dfp_attach_in, dfp_detach_in, dfp_disc_done_in, dfp_dev_is_hub_in, dfp_disc_req_out;
    logic [3:0] dfp_notify_en_out, dfp_path_en_out, dfp_port_reset_out, dfp_ess_tunnel_out, dfp_dp_tunnel_out;
    logic [3:0] dfp_eusb_send_out, dfp_eusb_hp_out, dev_hub;
    logic [31:0] reg_wdata_in, reg_rdata_out, v;
    logic [1:0] enter_usb_op_in, ufp_link_proto_in;
    logic [3:1] enter_usb_feat_in;
    logic [4:0] host_cap_out;
    logic [15:0] dfp_dev_caps_in, dev_caps;
    logic [11:0] dfp_mode_out;
    logic [31:0] exp_q[$], msk_q[$];
    int num_errors = 0;
    int check_count = 0;

    hub_conn_policy #(.USB4_WAIT_CYC(32'h0000_0064), .ALT_WAIT_CYC(32'h0000_0064)) DUT (.*);
    dfp_partner_model #(.NPORTS(NPORTS)) u_partner (.core_clk_in, .rst_n_in, .caps_in(dev_caps),
        .is_hub_in(dev_hub), .disc_req_in(dfp_disc_req_out), .disc_done_out(dfp_disc_done_in),
        .dev_caps_out(dfp_dev_caps_in), .dev_is_hub_out(dfp_dev_is_hub_in));

    // 25 MHz core clock
    initial begin
        core_clk_in = 1'b0;
        forever #20 core_clk_in = ~core_clk_in;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_in);
    endtask
    // One register cycle; a read notes its expected data for the watcher
    task automatic reg_op(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [31:0] m);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= wr;
        reg_rd_in <= !wr;
        if (!wr) begin
            exp_q.push_back(d & m);
            msk_q.push_back(m);
        end
        @(posedge core_clk_in);
        reg_wr_in <= 1'b0;
        reg_rd_in <= 1'b0;
    endtask
    // One-cycle event pulses from the message layer and port managers
    task automatic pulse(input logic att, input logic drst, input logic [3:0] dfp, input logic cdone);
        @(posedge core_clk_in);
        {ufp_attach_in, data_reset_in, dfp_attach_in, ufp_contract_done_in} <= {att, drst, dfp, cdone};
        @(posedge core_clk_in);
        {ufp_attach_in, data_reset_in, dfp_attach_in, ufp_contract_done_in} <= 7'h00;
    endtask
    task automatic msg(input logic [1:0] op, input logic hp);
        @(posedge core_clk_in);
        {enter_usb_rx_in, enter_usb_op_in, enter_usb_host_present_in} <= {1'b1, op, hp};
        @(posedge core_clk_in);
        enter_usb_rx_in <= 1'b0;
    endtask
    task automatic ports(input logic [11:0] modes, input logic [3:0] path);
        #1;
        chk(dfp_mode_out, modes);
        chk(dfp_path_en_out, path);
    endtask
    task automatic do_reset();
        rst_n_in <= 1'b0;
        tick(12);
        rst_n_in <= 1'b1;
        tick(1);
    endtask
    task automatic end_of_test();
        if (num_errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Read data stands in the cycle after the strobe, so look mid-cycle
    always @(posedge core_clk_in) rd_d <= reg_rd_in;
    always @(negedge core_clk_in) begin
        if (rd_d === 1'b1)
            chk(reg_rdata_out & msk_q.pop_front(), exp_q.pop_front());
    end

    // Whole run is under 1000 cycles; three times that means a hang
    initial begin
        #(40 * 3000);
        num_errors++;
        end_of_test();
    end

    initial begin
        v = $urandom(99259);
        {reg_wr_in, reg_rd_in, ufp_contract_done_in, ufp_is_source_in, ufp_is_host_role_in} = 5'h00;
        {ufp_attach_in, data_reset_in, enter_usb_rx_in, enter_usb_host_present_in, ufp_partner_is_hub_in} = 5'h00;
        {enter_mode_rx_in, enter_mode_vtun_in, enter_mode_dp_in, ufp_link_up_in, ufp_link_proto_in} = 6'h00;
        {reg_addr_in, reg_wdata_in, enter_usb_op_in, dfp_attach_in, dfp_detach_in} = 46'h0;
        enter_usb_feat_in = 3'h7;
        dev_caps = 16'h137f;
        dev_hub = 4'h1;
        do_reset();
        // Reset values, random control write back, unmapped offset
        reg_op(1'b0, `REG_CTRL, 32'h0000_0000, 32'h0000_0007);
        reg_op(1'b0, `REG_STATUS, 32'h0000_0400, 32'h0000_ffff);
        v = $urandom;
        ufp_is_source_in <= v[2];
        reg_op(1'b1, `REG_CTRL, {30'h0, v[1:0]}, 32'h0000_0000);
        reg_op(1'b0, `REG_CTRL, {30'h0, v[1:0]}, 32'h0000_0003);
        reg_op(1'b0, 4'h2, 32'h0000_0000, 32'hffff_ffff);
        ufp_is_host_role_in <= 1'b1;
        pulse(1'b0, 1'b0, 4'h0, 1'b1);
        #1 chk(dr_swap_req_out, 1'b1);
        chk(pr_swap_req_out, v[0] && (v[2] != v[1]));
        // Speculative ports, then a hub upstream holding back a 3.2 host
        ufp_link_up_in <= 1'b1;
        ufp_link_proto_in <= `OP_USB32;
        ufp_partner_is_hub_in <= 1'b1;
        pulse(1'b0, 1'b0, 4'hf, 1'b0);
        tick(20);
        ports(12'h8d1, 4'h0);
        chk(dfp_notify_en_out, 4'h0);
        pulse(1'b1, 1'b0, 4'h0, 1'b0);
        msg(`OP_USB4, 1'b0);
        tick(10);
        #1 chk(host_known_out, 1'b0);
        msg(`OP_USB32, 1'b1);
        tick(4);
        #1 chk(host_known_out, 1'b1);
        reg_op(1'b0, `REG_STATUS, 32'h0000_6003, 32'h0000_e01f);
        tick(100);
        ports(12'h964, 4'hf);
        // USB4 host: every speculative connection stays
        do_reset();
        ufp_partner_is_hub_in <= 1'b0;
        ufp_link_proto_in <= `OP_USB4;
        pulse(1'b1, 1'b0, 4'hf, 1'b0);
        tick(20);
        msg(`OP_USB4, 1'b1);
        tick(20);
        ports(12'h8d1, 4'hf);
        chk(dfp_ess_tunnel_out[3:2], 2'b11);
        chk(dfp_dp_tunnel_out[2], 1'b1);
        chk(dfp_eusb_hp_out[0], 1'b1);
        // No message at all: data reset restarts the entry wait
        do_reset();
        pulse(1'b1, 1'b0, 4'h0, 1'b0);
        tick(60);
        pulse(1'b0, 1'b1, 4'h0, 1'b0);
        tick(60);
        #1 chk(billboard_out, 1'b0);
        tick(60);
        reg_op(1'b0, `REG_STATUS, 32'h0000_8003, 32'h0000_801f);
        // Data reset clears billboard, then a display alternate mode sets the host view
        pulse(1'b0, 1'b1, 4'h0, 1'b0);
        {enter_mode_rx_in, enter_mode_dp_in} <= 2'b11;
        @(posedge core_clk_in) enter_mode_rx_in <= 1'b0;
        tick(3);
        #1 chk(host_cap_out, 5'h07);
        chk(billboard_out, 1'b0);
        end_of_test();
    end
endmodule

bind hub_conn_policy hub_conn_policy_checker #(.NPORTS(NPORTS)) u_chk (.*);
